// [pkg/eac_params.svh]
// Purpose: Constants of the non-volatile byte access controller
// Assumes: I/O offsets as seen by IN/OUT; data space adds the load/store offset
// Notes: Oscillator counts are in calibrated oscillator ticks; arm and stall counts are core clock cycles
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

`define EAC_DATA_SPACE_OFS 8'h20
`define EAC_BIT_IO_LAST 6'h1f
`define EAC_OFS_CONTROL 6'h1f
`define EAC_OFS_DATA 6'h20
`define EAC_OFS_ADDR_LO 6'h21
`define EAC_OFS_ADDR_HI 6'h22

`define EAC_BIT_READ 0
`define EAC_BIT_STROBE 1
`define EAC_BIT_ARM 2
`define EAC_BIT_RIE 3
`define EAC_BIT_MODE_LO 4
`define EAC_BIT_MODE_HI 5

`define EAC_MODE_RESET 2'h0
`define EAC_ARM_CYCLES 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_READ_STALL 3'h4

`define EAC_OSC_CYCLES_ATOMIC 26368
`define EAC_OSC_CYCLES_HALF 14060

`endif

// [pkg/eac_pkg.sv]
// Purpose: Types of the non-volatile byte access controller
// Assumes: Constants live in eac_params.svh
// Notes: None
package eac_pkg;
    typedef enum logic [1:0] {
        EAC_MODE_ERASE_WRITE = 2'b00,
        EAC_MODE_ERASE = 2'b01,
        EAC_MODE_WRITE = 2'b10,
        EAC_MODE_RSVD = 2'b11
    } eac_mode_t;

    typedef enum logic [1:0] {
        EAC_ST_IDLE = 2'b00,
        EAC_ST_PROG = 2'b01
    } eac_state_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] bit_mask;
    } eac_cpu_req_t;

    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [7:0] data;
        eac_mode_t mode;
    } eac_array_cmd_t;
endpackage

// [design/eac_osc_timer.sv]
// Purpose: Counts calibrated oscillator ticks for one programming operation
// Assumes: Oscillator tick is a one-cycle pulse synchronous to i_clk
// Notes: Length is loaded at start; done pulses once on expiry
`timescale 1ns/10ps
module eac_osc_timer #(
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [CNT_W-1:0] i_len,
    input wire logic i_tick,
    output logic o_busy,
    output logic o_done
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;

    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (i_start) begin
            cnt_next = i_len;
            busy_next = 1'b1;
        end else if (busy_reg && i_tick) begin
            if (cnt_reg <= CNT_W'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg - CNT_W'(1);
            end
        end
        // Reset leaves a running count alone so an operation in flight completes;
        // an unknown power-up state falls to the default branch and counts as idle
        if (i_srst) begin
            case (busy_reg)
                1'b1: ;
                default: begin
                    busy_next = 1'b0;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // Done is not reset, so an operation that ends during reset still releases the strobe
    always_ff @(posedge i_clk) begin
        cnt_reg <= cnt_next;
        done_reg <= done_next;
        busy_reg <= busy_next;
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
endmodule

// [design/eac_ctrl.sv]
// Purpose: CPU-facing register file and sequencer for byte-wide EEPROM access
// Assumes: CPU presents one I/O request per cycle; array read data is combinational
// Notes: Stall output holds the CPU; ready interrupt is a level
`timescale 1ns/10ps
`include "eac_params.svh"
module eac_ctrl #(
    parameter int ADDR_W = 10,
    parameter int OSC_CNT_W = 16,
    parameter int OSC_ATOMIC = `EAC_OSC_CYCLES_ATOMIC,
    parameter int OSC_HALF = `EAC_OSC_CYCLES_HALF
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire eac_pkg::eac_cpu_req_t i_cpu,
    input wire logic i_cpu_data_space,
    input wire logic i_global_irq_en,
    input wire logic i_self_program_busy,
    input wire logic i_osc_tick,
    input wire logic [7:0] i_array_rdata,
    output logic [7:0] o_cpu_rdata,
    output logic o_cpu_hit,
    output logic o_cpu_stall,
    output logic o_ready_irq,
    output eac_pkg::eac_array_cmd_t o_array_cmd,
    output logic o_array_rd,
    output logic [ADDR_W-1:0] o_array_addr
);
    // Map a CPU address onto the I/O offset; load/store space is shifted
    function automatic logic [6:0] io_index(input logic [7:0] a, input logic ds);
        logic [7:0] t;
        t = ds ? (a - `EAC_DATA_SPACE_OFS) : a;
        // Only the 64-entry I/O window decodes, so extended space never aliases
        if ((ds && a < `EAC_DATA_SPACE_OFS) || t[7:6] != 2'b00) begin
            io_index = 7'h7f;
        end else begin
            io_index = t[6:0];
        end
    endfunction

    // Merge a write: bit instructions change only the masked bits
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] msk);
        merge = (old & ~msk) | (wd & msk);
    endfunction

    logic [6:0] idx;
    logic sel_ctl, sel_dat, sel_alo, sel_ahi, bit_ok;
    logic [7:0] wmask;
    logic [7:0] ctl_view, ctl_w;
    logic [7:0] ahi_w;

    eac_pkg::eac_mode_t mode_reg, mode_next;
    logic rie_reg, rie_next;
    logic arm_reg, arm_next;
    logic [2:0] arm_cnt_reg, arm_cnt_next;
    logic strobe_reg, strobe_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] stall_reg, stall_next;
    eac_pkg::eac_state_t st_reg, st_next;
    eac_pkg::eac_array_cmd_t cmd_reg, cmd_next;
    logic rd_reg, rd_next;
    logic [7:0] rdata_reg, rdata_next;
    logic hit_reg, hit_next;

    logic tmr_start;
    logic [OSC_CNT_W-1:0] tmr_len;
    logic tmr_busy, tmr_done;
    logic busy;

    assign idx = io_index(i_cpu.addr, i_cpu_data_space);
    assign sel_ctl = i_cpu.req && idx == 7'(`EAC_OFS_CONTROL);
    assign sel_dat = i_cpu.req && idx == 7'(`EAC_OFS_DATA);
    assign sel_alo = i_cpu.req && idx == 7'(`EAC_OFS_ADDR_LO);
    assign sel_ahi = i_cpu.req && idx == 7'(`EAC_OFS_ADDR_HI);
    // Bit masks only apply in the bit-addressable range; elsewhere full byte
    assign bit_ok = i_cpu_data_space ? 1'b0 : (idx <= 7'(`EAC_BIT_IO_LAST));
    assign wmask = bit_ok ? i_cpu.bit_mask : 8'hff;
    assign busy = st_reg == eac_pkg::EAC_ST_PROG;

    assign ctl_view = {2'h0, mode_reg, rie_reg, arm_reg, strobe_reg, 1'b0};
    assign ctl_w = merge(ctl_view, i_cpu.wdata, wmask);
    assign ahi_w = merge(8'(addr_reg[ADDR_W-1:8]), i_cpu.wdata, wmask);

    always_comb begin
        mode_next = mode_reg;
        rie_next = rie_reg;
        arm_next = arm_reg;
        arm_cnt_next = arm_cnt_reg;
        strobe_next = strobe_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        stall_next = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
        st_next = st_reg;
        cmd_next = cmd_reg;
        cmd_next.wr = 1'b0;
        rd_next = 1'b0;
        tmr_start = 1'b0;
        tmr_len = OSC_CNT_W'(OSC_ATOMIC);

        // Arm window counts down and drops itself
        if (arm_reg) begin
            if (arm_cnt_reg <= 3'h1) begin
                arm_next = 1'b0;
                arm_cnt_next = 3'h0;
            end else begin
                arm_cnt_next = arm_cnt_reg - 3'h1;
            end
        end

        if (tmr_done) begin
            strobe_next = 1'b0;
            st_next = eac_pkg::EAC_ST_IDLE;
        end

        if (i_cpu.wr && sel_ctl) begin
            rie_next = ctl_w[`EAC_BIT_RIE];
            if (!strobe_reg) begin
                mode_next = eac_pkg::eac_mode_t'(ctl_w[`EAC_BIT_MODE_HI:`EAC_BIT_MODE_LO]);
            end
            if (ctl_w[`EAC_BIT_ARM] && !ctl_view[`EAC_BIT_ARM]) begin
                arm_next = 1'b1;
                arm_cnt_next = `EAC_ARM_CYCLES;
            end
            // Strobe needs the arm bit as it stands, idle array and idle flash writer
            if (ctl_w[`EAC_BIT_STROBE] && !strobe_reg && arm_reg && !busy
                && !i_self_program_busy) begin
                arm_next = 1'b0;
                arm_cnt_next = 3'h0;
                stall_next = `EAC_WRITE_STALL;
                if (mode_next == eac_pkg::EAC_MODE_RSVD) begin
                    strobe_next = 1'b0;
                end else begin
                    strobe_next = 1'b1;
                    st_next = eac_pkg::EAC_ST_PROG;
                    tmr_start = 1'b1;
                    tmr_len = (mode_next == eac_pkg::EAC_MODE_ERASE_WRITE) ?
                              OSC_CNT_W'(OSC_ATOMIC) : OSC_CNT_W'(OSC_HALF);
                    cmd_next.wr = 1'b1;
                    cmd_next.addr = addr_reg;
                    cmd_next.data = data_reg;
                    cmd_next.mode = mode_next;
                end
            end
            if (ctl_w[`EAC_BIT_READ] && !busy) begin
                data_next = i_array_rdata;
                rd_next = 1'b1;
                stall_next = `EAC_READ_STALL;
            end
        end

        if (i_cpu.wr && sel_dat) begin
            data_next = merge(data_reg, i_cpu.wdata, wmask);
        end
        if (i_cpu.wr && sel_alo && !busy) begin
            addr_next[7:0] = merge(addr_reg[7:0], i_cpu.wdata, wmask);
        end
        if (i_cpu.wr && sel_ahi && !busy) begin
            addr_next[ADDR_W-1:8] = ahi_w[ADDR_W-9:0];
        end

        if (i_srst) begin
            rie_next = 1'b0;
            arm_next = 1'b0;
            arm_cnt_next = 3'h0;
            stall_next = 3'h0;
            rd_next = 1'b0;
            cmd_next.wr = 1'b0;
            if (!tmr_busy || tmr_done) begin
                mode_next = eac_pkg::eac_mode_t'(`EAC_MODE_RESET);
                strobe_next = 1'b0;
                st_next = eac_pkg::EAC_ST_IDLE;
            end
        end
    end

    always_comb begin
        hit_next = sel_ctl || sel_dat || sel_alo || sel_ahi;
        rdata_next = 8'h00;
        if (sel_ctl) begin
            rdata_next = ctl_view;
        end else if (sel_dat) begin
            rdata_next = data_reg;
        end else if (sel_alo) begin
            rdata_next = addr_reg[7:0];
        end else if (sel_ahi) begin
            rdata_next = {6'h0, addr_reg[ADDR_W-1:8]};
        end
    end

    // Address and data have no reset value by design; software must load them
    always_ff @(posedge i_clk) begin
        mode_reg <= mode_next;
        rie_reg <= rie_next;
        arm_reg <= arm_next;
        arm_cnt_reg <= arm_cnt_next;
        strobe_reg <= strobe_next;
        addr_reg <= addr_next;
        data_reg <= data_next;
        stall_reg <= stall_next;
        st_reg <= st_next;
        cmd_reg <= cmd_next;
        rd_reg <= rd_next;
        rdata_reg <= i_srst ? 8'h00 : rdata_next;
        hit_reg <= i_srst ? 1'b0 : hit_next;
    end

    eac_osc_timer #(
        .CNT_W(OSC_CNT_W)
    ) u_timer (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_start(tmr_start),
        .i_len(tmr_len),
        .i_tick(i_osc_tick),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    always_comb begin
        case (st_reg)
            eac_pkg::EAC_ST_IDLE: o_ready_irq = rie_reg && i_global_irq_en && !strobe_reg
                                                && !i_self_program_busy;
            eac_pkg::EAC_ST_PROG: o_ready_irq = 1'b0;
            default: o_ready_irq = 1'b0;
        endcase
    end

    assign o_cpu_stall = stall_reg != 3'h0;
    assign o_cpu_rdata = rdata_reg;
    assign o_cpu_hit = hit_reg;
    assign o_array_cmd = cmd_reg;
    assign o_array_rd = rd_reg;
    assign o_array_addr = addr_reg;
endmodule

// [bench/eac_ctrl_props.sv]
// Purpose: Port-level checks of the byte access controller
// Assumes: CPU never issues a request while stalled
// Notes: Busy windows use 8 cycles, below any real programming time
`timescale 1ns/10ps
module eac_ctrl_props #(
    parameter int ADDR_W = 10
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire eac_pkg::eac_cpu_req_t i_cpu,
    input wire logic i_cpu_data_space,
    input wire logic i_global_irq_en,
    input wire logic i_self_program_busy,
    input wire logic [7:0] o_cpu_rdata,
    input wire logic o_cpu_hit,
    input wire logic o_cpu_stall,
    input wire logic o_ready_irq,
    input wire eac_pkg::eac_array_cmd_t o_array_cmd,
    input wire logic o_array_rd,
    input wire logic [ADDR_W-1:0] o_array_addr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [7:0] io_a;
    logic hit_map;
    logic cpu_rd;
    // Data space view folds back onto the I/O offsets
    assign io_a = i_cpu.addr - {2'b00, i_cpu_data_space, 5'h00};
    assign hit_map = io_a >= 8'h1f && io_a <= 8'h22;
    assign cpu_rd = i_cpu.req && i_cpu.rd && !o_cpu_stall;
    a_map_hit: assert property (i_cpu.req && !o_cpu_stall |=> o_cpu_hit == $past(hit_map))
        else $error("register hit does not match address map");
    a_rsvd_zero: assert property (cpu_rd && io_a == 8'h22 |=> o_cpu_rdata[7:2] == 6'h00)
        else $error("upper address bits read nonzero");
    a_cmd_addr: assert property (o_array_cmd.wr |-> o_array_cmd.addr == o_array_addr)
        else $error("array command address differs from address register");
    a_irq_gate: assert property (!i_global_irq_en || i_self_program_busy |-> !o_ready_irq)
        else $error("ready interrupt while disabled or self-write busy");
    a_irq_busy: assert property (o_array_cmd.wr |-> !o_ready_irq [*8])
        else $error("ready interrupt during programming");
    a_self_write_start: assert property (o_array_cmd.wr |-> !$past(i_self_program_busy))
        else $error("programming started during self-write");
    a_write_stall: assert property (o_array_cmd.wr |-> o_cpu_stall ##1 o_cpu_stall ##1 !o_cpu_stall)
        else $error("write stall is not two cycles");
    a_read_stall: assert property (o_array_rd |-> o_cpu_stall [*4] ##1 !o_cpu_stall)
        else $error("read stall is not four cycles");
    a_busy_noread: assert property (o_array_cmd.wr |=> !o_array_rd [*8])
        else $error("array read during programming");
    a_busy_addr: assert property (o_array_cmd.wr |=> $stable(o_array_addr) [*8])
        else $error("address changed during programming");
endmodule

bind eac_ctrl eac_ctrl_props #(.ADDR_W(ADDR_W)) eac_ctrl_props_inst (.i_clk, .i_srst, .i_cpu,
    .i_cpu_data_space, .i_global_irq_en, .i_self_program_busy, .o_cpu_rdata, .o_cpu_hit,
    .o_cpu_stall, .o_ready_irq, .o_array_cmd, .o_array_rd, .o_array_addr);

// [bench/eac_array_model.sv]
// Purpose: Byte array and oscillator stand-in
// Assumes: Oscillator ticks every other clock
// Notes: Write-only can only clear bits, as a real cell would
`timescale 1ns/10ps
module eac_array_model (
    input wire logic i_clk,
    input wire eac_pkg::eac_array_cmd_t i_cmd,
    input wire logic [9:0] i_addr,
    output logic [7:0] o_rdata,
    output logic o_tick
);
    logic [7:0] mem [1024];
    initial begin
        o_tick = 1'b0;
        for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h3c;
    end
    always @(posedge i_clk) begin
        o_tick <= ~o_tick;
        if (i_cmd.wr === 1'b1) begin
            case (i_cmd.mode)
                eac_pkg::EAC_MODE_ERASE_WRITE: mem[i_cmd.addr] <= i_cmd.data;
                eac_pkg::EAC_MODE_ERASE: mem[i_cmd.addr] <= 8'hff;
                eac_pkg::EAC_MODE_WRITE: mem[i_cmd.addr] <= mem[i_cmd.addr] & i_cmd.data;
                default: ;
            endcase
        end
    end
    assign o_rdata = mem[i_addr];
endmodule

// [bench/eac_ctrl_tb.sv]
// Purpose: Self-checking bench for the byte access controller
// Assumes: Oscillator counts shortened to 20 and 10 ticks
// Notes: Strobe bit is polled as the busy flag
`timescale 1ns/10ps
module eac_ctrl_tb;
    localparam int LEN_A = 20;
    localparam int LEN_H = 10;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    eac_pkg::eac_cpu_req_t i_cpu = '0;
    logic i_cpu_data_space = 1'b0, i_global_irq_en = 1'b0, i_self_program_busy = 1'b0;
    logic i_osc_tick, o_cpu_hit, o_cpu_stall, o_ready_irq, o_array_rd, hit_q;
    logic [7:0] i_array_rdata, o_cpu_rdata, got;
    logic [9:0] o_array_addr;
    eac_pkg::eac_array_cmd_t o_array_cmd, last;
    int n_fail = 0, checks_done = 0, cyc = 0, n_cmd = 0, n_rd = 0, t_cmd = 0, el;
    eac_ctrl #(.OSC_ATOMIC(LEN_A), .OSC_HALF(LEN_H)) eac_ctrl_inst (.i_clk, .i_srst, .i_cpu,
        .i_cpu_data_space, .i_global_irq_en, .i_self_program_busy, .i_osc_tick, .i_array_rdata,
        .o_cpu_rdata, .o_cpu_hit, .o_cpu_stall, .o_ready_irq, .o_array_cmd, .o_array_rd, .o_array_addr);
    eac_array_model eac_array_model_inst (.i_clk, .i_cmd(o_array_cmd), .i_addr(o_array_addr),
        .o_rdata(i_array_rdata), .o_tick(i_osc_tick));
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (o_array_cmd.wr === 1'b1) begin
            n_cmd++;
            t_cmd = cyc;
            last = o_array_cmd;
        end
        if (o_array_rd === 1'b1) n_rd++;
    end
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // CPU is held while stalled, so no request goes out then
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
        // An idle cycle between requests keeps each request line to one assignment per step
        @(negedge i_clk);
        for (int n = 0; o_cpu_stall !== 1'b0; n++) begin
            if (n > 20) begin
                n_fail++;
                finish_test();
            end
            @(negedge i_clk);
        end
        i_cpu = '{1'b1, w, !w, a, d, m};
        @(negedge i_clk);
        i_cpu = '0;
        got = o_cpu_rdata;
        hit_q = o_cpu_hit;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k = 8'hff);
        io(1'b0, a, 8'h00);
        chk(24'(got & k), 24'(e));
    endtask
    task automatic poll();
        for (int n = 0; n < 200; n++) begin
            io(1'b0, 8'h1f, 8'h00);
            if (got[1] === 1'b0) begin
                el = cyc - t_cmd;
                return;
            end
        end
        n_fail++;
        finish_test();
    endtask
    task automatic prog(input logic [1:0] m, input logic [7:0] d, input int len);
        int k;
        int r;
        k = n_cmd;
        r = n_rd;
        i_global_irq_en = 1'b0;
        io(1'b1, 8'h20, d);
        io(1'b1, 8'h1f, {2'b00, m, 4'hc});
        io(1'b1, 8'h1f, {2'b00, m, 4'he});
        i_global_irq_en = 1'b1;
        rd(8'h1f, {2'b00, m, 4'ha}, 8'hfb);
        chk(24'(o_ready_irq), 24'h0);
        // Mode change plus read strobe while busy: both must be dropped
        io(1'b1, 8'h1f, {2'b00, ~m, 4'hb});
        io(1'b1, 8'h21, 8'h00);
        rd(8'h1f, {2'b00, m, 4'ha}, 8'hfb);
        chk(24'(o_array_addr), 24'h15a);
        chk(24'(n_rd - r), 24'h0);
        poll();
        chk(24'(el >= 2 * len && el <= 2 * len + 8), 24'h1);
        chk(24'(n_cmd - k), 24'h1);
        chk(24'(last), {4'b0001, 10'h15a, d, m});
        chk(24'(o_ready_irq), 24'h1);
    endtask
    initial begin
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        rd(8'h1f, 8'h00);
        io(1'b1, 8'h22, 8'hff);
        rd(8'h22, 8'h03);
        io(1'b1, 8'h21, 8'h5a);
        chk(24'(o_array_addr), 24'h35a);
        i_cpu_data_space = 1'b1;
        io(1'b1, 8'h42, 8'h01);
        rd(8'h42, 8'h01);
        io(1'b0, 8'h1f, 8'h00);
        chk(24'(hit_q), 24'h0);
        i_cpu_data_space = 1'b0;
        rd(8'h22, 8'h01);
        io(1'b1, 8'h1f, 8'h08);
        io(1'b1, 8'h1f, 8'h04, 8'h04);
        rd(8'h1f, 8'h0c);
        repeat (4) @(negedge i_clk);
        rd(8'h1f, 8'h08);
        io(1'b1, 8'h1f, 8'h0a);
        rd(8'h1f, 8'h08);
        i_global_irq_en = 1'b1;
        @(negedge i_clk);
        chk(24'(o_ready_irq), 24'h1);
        i_self_program_busy = 1'b1;
        io(1'b1, 8'h1f, 8'h0c);
        io(1'b1, 8'h1f, 8'h0e);
        rd(8'h1f, 8'h08, 8'hfb);
        chk(24'(o_ready_irq), 24'h0);
        i_self_program_busy = 1'b0;
        prog(2'b00, 8'ha5, LEN_A);
        io(1'b1, 8'h1f, 8'h09);
        rd(8'h20, 8'ha5);
        chk(24'(n_rd), 24'h1);
        prog(2'b01, 8'h0f, LEN_H);
        prog(2'b10, 8'h0f, LEN_H);
        io(1'b1, 8'h1f, 8'h09);
        rd(8'h20, 8'h0f);
        io(1'b1, 8'h1f, 8'h3c);
        io(1'b1, 8'h1f, 8'h3e);
        rd(8'h1f, 8'h38, 8'hfb);
        chk(24'(n_cmd), 24'h3);
        io(1'b1, 8'h1f, 8'h2c);
        io(1'b1, 8'h1f, 8'h2e);
        i_srst = 1'b1;
        @(negedge i_clk);
        i_srst = 1'b0;
        rd(8'h1f, 8'h22, 8'hfb);
        poll();
        rd(8'h1f, 8'h20);
        i_srst = 1'b1;
        @(negedge i_clk);
        i_srst = 1'b0;
        rd(8'h1f, 8'h00);
        finish_test();
    end
endmodule
